/* hdl/dual_comparator_control_pkg.sv */
// constants, field layouts and carrier types for the dual comparator control block
// assumes a 32-bit APB master, two analog comparator cores and six shared pins
//
// Functional notes
// - two independent comparator channels, each with its own identical eight-bit control word
// - bit 6 powers the comparator on when 1, off when 0; resets to 0
// - bit 5 inverts the recorded output bit when 1; resets to 0
// - read-only bit 4 holds the result, positive above negative reads 1 uninverted
// - bit 0 turns hysteresis on when 1; resets to 1
// - bits 7 and 3 to 1 read zero and ignore writes
// - an enabled comparator cuts the pull-high on its shared input pins
// - each comparator result can also be driven onto a shared pin
// - a change of the recorded result bit sets the channel flag, not the pin
// - flag plus enable raises that channel's own interrupt request
// - in sleep or idle, a flag-setting change of an enabled comparator wakes
// - an enabled comparator keeps working in sleep or idle mode
// - with comparator on, port read gives 0 when direction is 1, else data latch
package dual_comparator_control_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int NUM_CMP = 2;
  localparam int PINS_PER_CMP = 3;
  localparam int NUM_PINS = NUM_CMP * PINS_PER_CMP;

  localparam logic [ADDR_W-1:0] OFF_CTRL_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_ONE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PORT_DIR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PORT_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PORT_READ = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PULL_ENABLE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_OUT_SELECT = 8'h20;

  localparam int BIT_POWER = 6;
  localparam int BIT_INVERT = 5;
  localparam int BIT_RESULT = 4;
  localparam int BIT_HYST = 0;

  // pin roles inside one channel's group of three
  localparam int PIN_POS = 0;
  localparam int PIN_NEG = 1;
  localparam int PIN_OUT = 2;

  localparam logic RST_POWER = 1'b0;
  localparam logic RST_INVERT = 1'b0;
  localparam logic RST_RESULT = 1'b0;
  localparam logic RST_HYST = 1'b1;
  localparam logic [NUM_CMP-1:0] RST_INT_STATUS = 2'h0;
  localparam logic [NUM_CMP-1:0] RST_INT_MASK = 2'h0;
  localparam logic [NUM_CMP-1:0] RST_OUT_SELECT = 2'h0;
  localparam logic [NUM_PINS-1:0] RST_PORT_DIR = 6'h3F;
  localparam logic [NUM_PINS-1:0] RST_PORT_DATA = 6'h00;
  localparam logic [NUM_PINS-1:0] RST_PULL_ENABLE = 6'h00;

  typedef struct packed {
    logic powerOn;
    logic invert;
    logic hysteresisOn;
  } cmp_ctrl_s;

  localparam cmp_ctrl_s CTRL_RESET = '{powerOn: RST_POWER, invert: RST_INVERT,
                                       hysteresisOn: RST_HYST};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_s;
endpackage

/* hdl/comparator_channel.sv */
// one comparator channel: result synchroniser, polarity and change detect
// assumes analogResult is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module comparator_channel (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic analogResult,
  input wire dual_comparator_control_pkg::cmp_ctrl_s ctrl,
  output logic result,
  output logic changed
);
  import dual_comparator_control_pkg::*;

  logic syncFirst;
  logic syncSecond;
  logic [1:0] warmUp;
  logic next_result;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      syncFirst <= 1'b0;
      syncSecond <= 1'b0;
    end else begin
      syncFirst <= analogResult;
      syncSecond <= syncFirst;
    end
  end

  // the sync flops still carry pre-power garbage for two edges after power-on,
  // so the result waits until they have refilled with a live value
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      warmUp <= 2'h0;
    end else if (!ctrl.powerOn) begin
      warmUp <= 2'h0;
    end else begin
      warmUp <= {warmUp[0], 1'b1};
    end
  end

  // a powered-off core has no valid output, so the last result is held
  always_comb begin
    next_result = result;
    if (ctrl.powerOn && warmUp[1]) begin
      next_result = syncSecond ^ ctrl.invert;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      result <= RST_RESULT;
    end else begin
      result <= next_result;
    end
  end

  // toggling polarity also counts as a change of the recorded bit
  assign changed = (next_result != result);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_polarity_applied;
    $past(ctrl.powerOn && warmUp[1]) |-> result == ($past(syncSecond) ^ $past(ctrl.invert));
  endproperty
  a_polarity_applied: assert property (p_polarity_applied)
    else $error("result does not follow synchronised input and polarity");

  property p_off_holds;
    !$past(ctrl.powerOn && warmUp[1]) |-> $stable(result);
  endproperty
  a_off_holds: assert property (p_off_holds)
    else $error("result moved while comparator was off");
endmodule
`default_nettype wire

/* hdl/dual_comparator_control.sv */
// top of the dual comparator control block: APB registers, interrupts, wake and pins
// assumes APB master on clk_sys; pad levels arrive synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control (
  input wire logic clk_sys,
  input wire logic reset,
  input wire dual_comparator_control_pkg::apb_req_s apbReq,
  output dual_comparator_control_pkg::apb_rsp_s apbRsp,
  input wire logic [dual_comparator_control_pkg::NUM_CMP-1:0] analogResult,
  output logic [dual_comparator_control_pkg::NUM_CMP-1:0] cmpPowerOn,
  output logic [dual_comparator_control_pkg::NUM_CMP-1:0] cmpHysteresisOn,
  input wire logic [dual_comparator_control_pkg::NUM_PINS-1:0] padIn,
  output logic [dual_comparator_control_pkg::NUM_PINS-1:0] padOut,
  output logic [dual_comparator_control_pkg::NUM_PINS-1:0] padOe,
  output logic [dual_comparator_control_pkg::NUM_PINS-1:0] pullHighOn,
  input wire logic sleepMode,
  output logic wakeup,
  output logic irq,
  output logic [dual_comparator_control_pkg::NUM_CMP-1:0] irqRequest
);
  import dual_comparator_control_pkg::*;

  cmp_ctrl_s ctrlReg [NUM_CMP];
  logic [NUM_CMP-1:0] cmpResult;
  logic [NUM_CMP-1:0] cmpChanged;
  logic [NUM_CMP-1:0] intStatus;
  logic [NUM_CMP-1:0] intMask;
  logic [NUM_CMP-1:0] outSelect;
  logic [NUM_PINS-1:0] portDir;
  logic [NUM_PINS-1:0] portData;
  logic [NUM_PINS-1:0] pullEnable;
  logic [NUM_PINS-1:0] portReadValue;
  logic [NUM_PINS-1:0] next_padOut;
  logic [NUM_PINS-1:0] next_padOe;
  logic [NUM_PINS-1:0] next_pullHighOn;
  logic [NUM_CMP-1:0] next_intStatus;
  logic [NUM_CMP-1:0] statusClear;
  logic [NUM_CMP-1:0] statusSoftSet;
  logic [DATA_W-1:0] readData;
  logic addrHit;
  logic accessDone;
  logic writeDone;
  logic readDone;
  logic wakeEvent;

  function automatic logic [7:0] ctrlByte(input cmp_ctrl_s c, input logic res);
    logic [7:0] b;
    b = 8'h00;
    b[BIT_POWER] = c.powerOn;
    b[BIT_INVERT] = c.invert;
    b[BIT_RESULT] = res;
    b[BIT_HYST] = c.hysteresisOn;
    return b;
  endfunction

  function automatic logic [ADDR_W-1:0] ctrlOffset(input int idx);
    return (idx == 0) ? OFF_CTRL_ZERO : OFF_CTRL_ONE;
  endfunction

  // the access phase always lasts two cycles: one to sample, one with pready
  assign accessDone = apbReq.psel & apbReq.penable & apbRsp.pready;
  assign writeDone = accessDone & apbReq.pwrite;
  assign readDone = accessDone & ~apbReq.pwrite;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      comparator_channel u_channel (
        .clk_sys(clk_sys),
        .reset(reset),
        .analogResult(analogResult[gi]),
        .ctrl(ctrlReg[gi]),
        .result(cmpResult[gi]),
        .changed(cmpChanged[gi])
      );

      always_ff @(posedge clk_sys) begin
        if (reset) begin
          ctrlReg[gi] <= CTRL_RESET;
        end else if (writeDone && apbReq.paddr == ctrlOffset(gi)) begin
          // bit 4 is read-only and bits 7, 3..1 are not stored
          ctrlReg[gi].powerOn <= apbReq.pwdata[BIT_POWER];
          ctrlReg[gi].invert <= apbReq.pwdata[BIT_INVERT];
          ctrlReg[gi].hysteresisOn <= apbReq.pwdata[BIT_HYST];
        end
      end

      // core power follows the control bit only; sleep does not touch it
      assign cmpPowerOn[gi] = ctrlReg[gi].powerOn;
      assign cmpHysteresisOn[gi] = ctrlReg[gi].hysteresisOn;
    end
  endgenerate

  always_comb begin
    readData = '0;
    addrHit = 1'b1;
    case (apbReq.paddr)
      OFF_CTRL_ZERO: readData[7:0] = ctrlByte(ctrlReg[0], cmpResult[0]);
      OFF_CTRL_ONE: readData[7:0] = ctrlByte(ctrlReg[1], cmpResult[1]);
      OFF_INT_STATUS: readData[NUM_CMP-1:0] = intStatus;
      OFF_INT_MASK: readData[NUM_CMP-1:0] = intMask;
      OFF_PORT_DIR: readData[NUM_PINS-1:0] = portDir;
      OFF_PORT_DATA: readData[NUM_PINS-1:0] = portData;
      OFF_PORT_READ: readData[NUM_PINS-1:0] = portReadValue;
      OFF_PULL_ENABLE: readData[NUM_PINS-1:0] = pullEnable;
      OFF_OUT_SELECT: readData[NUM_CMP-1:0] = outSelect;
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      apbRsp <= '0;
    end else if (apbReq.psel && apbReq.penable && !apbRsp.pready) begin
      apbRsp.pready <= 1'b1;
      apbRsp.pslverr <= ~addrHit;
      apbRsp.prdata <= addrHit ? readData : '0;
    end else begin
      apbRsp.pready <= 1'b0;
      apbRsp.pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      intMask <= RST_INT_MASK;
      outSelect <= RST_OUT_SELECT;
      portDir <= RST_PORT_DIR;
      portData <= RST_PORT_DATA;
      pullEnable <= RST_PULL_ENABLE;
    end else if (writeDone) begin
      case (apbReq.paddr)
        OFF_INT_MASK: intMask <= apbReq.pwdata[NUM_CMP-1:0];
        OFF_OUT_SELECT: outSelect <= apbReq.pwdata[NUM_CMP-1:0];
        OFF_PORT_DIR: portDir <= apbReq.pwdata[NUM_PINS-1:0];
        OFF_PORT_DATA: portData <= apbReq.pwdata[NUM_PINS-1:0];
        OFF_PULL_ENABLE: pullEnable <= apbReq.pwdata[NUM_PINS-1:0];
        default: ;
      endcase
    end
  end

  // only bits that were actually returned are cleared, so an event arriving
  // between sampling and completion survives the read
  always_comb begin
    statusClear = '0;
    statusSoftSet = '0;
    if (readDone && apbReq.paddr == OFF_INT_STATUS) begin
      statusClear = apbRsp.prdata[NUM_CMP-1:0];
    end
    if (writeDone && apbReq.paddr == OFF_INT_STATUS) begin
      statusSoftSet = apbReq.pwdata[NUM_CMP-1:0];
    end
    next_intStatus = (intStatus & ~statusClear) | cmpChanged | statusSoftSet;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      intStatus <= RST_INT_STATUS;
    end else begin
      intStatus <= next_intStatus;
    end
  end

  // a flag already high gives no new wake, which is how software blocks it
  assign wakeEvent = sleepMode & |(cmpChanged & cmpPowerOn & ~intStatus);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wakeup <= 1'b0;
      irq <= 1'b0;
      irqRequest <= '0;
    end else begin
      wakeup <= wakeEvent;
      irq <= |(intStatus & intMask);
      irqRequest <= intStatus & intMask;
    end
  end

  always_comb begin
    portReadValue = '0;
    next_padOut = '0;
    next_padOe = '0;
    next_pullHighOn = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      int c;
      int role;
      c = p / PINS_PER_CMP;
      role = p % PINS_PER_CMP;
      if (ctrlReg[c].powerOn) begin
        portReadValue[p] = portDir[p] ? 1'b0 : portData[p];
      end else begin
        portReadValue[p] = portDir[p] ? padIn[p] : portData[p];
      end
      if (role == PIN_OUT && ctrlReg[c].powerOn && outSelect[c]) begin
        next_padOut[p] = cmpResult[c];
        next_padOe[p] = 1'b1;
      end else if (role != PIN_OUT && ctrlReg[c].powerOn) begin
        next_padOe[p] = 1'b0;
      end else begin
        next_padOut[p] = portData[p];
        next_padOe[p] = ~portDir[p];
      end
      // analog inputs must not be loaded by the pull-high while in use
      next_pullHighOn[p] = pullEnable[p] & ~(ctrlReg[c].powerOn & (role != PIN_OUT));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      padOut <= '0;
      padOe <= '0;
      pullHighOn <= '0;
    end else begin
      padOut <= next_padOut;
      padOe <= next_padOe;
      pullHighOn <= next_pullHighOn;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_ctrl_reserved_zero;
    (apbReq.psel && apbReq.penable && !apbRsp.pready && !apbReq.pwrite &&
     (apbReq.paddr == OFF_CTRL_ZERO || apbReq.paddr == OFF_CTRL_ONE))
      |=> apbRsp.prdata[31:7] == 25'h0 && apbRsp.prdata[3:1] == 3'h0;
  endproperty
  a_ctrl_reserved_zero: assert property (p_ctrl_reserved_zero)
    else $error("reserved control bits read non-zero");

  property p_power_write;
    (writeDone && apbReq.paddr == OFF_CTRL_ZERO) |=> cmpPowerOn[0] == $past(apbReq.pwdata[6]);
  endproperty
  a_power_write: assert property (p_power_write)
    else $error("power control did not take written value");

  property p_reset_values;
    $past(reset) |-> cmpHysteresisOn == 2'h3 && cmpPowerOn == 2'h0 && cmpResult == 2'h0;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("control bits wrong after reset");

  property p_flag_on_change;
    $changed(cmpResult[0]) |-> intStatus[0];
  endproperty
  a_flag_on_change: assert property (p_flag_on_change)
    else $error("result change did not set flag");

  property p_irq_request;
    irqRequest == $past(intStatus & intMask) && irq == |$past(intStatus & intMask);
  endproperty
  a_irq_request: assert property (p_irq_request)
    else $error("interrupt request does not follow flag and mask");

  property p_wake_on_change;
    (sleepMode && cmpChanged[0] && cmpPowerOn[0] && !intStatus[0]) |=> wakeup ##1 !wakeup;
  endproperty
  a_wake_on_change: assert property (p_wake_on_change)
    else $error("missing single wake pulse");

  property p_no_wake_flag_set;
    wakeup |-> $past(sleepMode) && |($past(cmpChanged) & ~$past(intStatus));
  endproperty
  a_no_wake_flag_set: assert property (p_no_wake_flag_set)
    else $error("wake without fresh flag in sleep");

  property p_pull_cut;
    $past(cmpPowerOn[0]) |-> pullHighOn[1:0] == 2'h0;
  endproperty
  a_pull_cut: assert property (p_pull_cut)
    else $error("pull-high left on enabled comparator input");

  property p_port_read_zero;
    (apbReq.psel && apbReq.penable && !apbRsp.pready && !apbReq.pwrite &&
     apbReq.paddr == OFF_PORT_READ && cmpPowerOn[1] && portDir[3])
      |=> apbRsp.prdata[3] == 1'b0;
  endproperty
  a_port_read_zero: assert property (p_port_read_zero)
    else $error("comparator pin read not zero");

  property p_out_pin;
    $past(cmpPowerOn[0] && outSelect[0]) |-> padOe[2] && padOut[2] == $past(cmpResult[0]);
  endproperty
  a_out_pin: assert property (p_out_pin)
    else $error("comparator output not on pin");

  property p_flag_on_change_one;
    $changed(cmpResult[1]) |-> intStatus[1];
  endproperty
  a_flag_on_change_one: assert property (p_flag_on_change_one)
    else $error("channel one result change did not set flag");

  property p_pull_cut_one;
    $past(cmpPowerOn[1]) |-> pullHighOn[4:3] == 2'h0;
  endproperty
  a_pull_cut_one: assert property (p_pull_cut_one)
    else $error("pull-high left on enabled channel one input");

  property p_inputs_released;
    $past(cmpPowerOn[0]) |-> padOe[1:0] == 2'h0;
  endproperty
  a_inputs_released: assert property (p_inputs_released)
    else $error("enabled comparator input pin is driven");

  property p_read_clears;
    (readDone && apbReq.paddr == OFF_INT_STATUS && apbRsp.prdata[0] && !cmpChanged[0])
      |=> !intStatus[0];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("returned flag not cleared by status read");

  property p_soft_set;
    (writeDone && apbReq.paddr == OFF_INT_STATUS && apbReq.pwdata[0]) |=> intStatus[0];
  endproperty
  a_soft_set: assert property (p_soft_set)
    else $error("software write did not set flag");

  property p_hyst_write;
    (writeDone && apbReq.paddr == OFF_CTRL_ZERO)
      |=> cmpHysteresisOn[0] == $past(apbReq.pwdata[BIT_HYST]);
  endproperty
  a_hyst_write: assert property (p_hyst_write)
    else $error("hysteresis control did not take written value");

  property p_power_write_one;
    (writeDone && apbReq.paddr == OFF_CTRL_ONE)
      |=> cmpPowerOn[1] == $past(apbReq.pwdata[BIT_POWER]);
  endproperty
  a_power_write_one: assert property (p_power_write_one)
    else $error("channel one power control did not take written value");

  property p_wake_needs_power;
    wakeup |-> |$past(cmpChanged & cmpPowerOn);
  endproperty
  a_wake_needs_power: assert property (p_wake_needs_power)
    else $error("wake without change of an enabled comparator");

  property p_result_read;
    (apbReq.psel && apbReq.penable && !apbRsp.pready && !apbReq.pwrite &&
     apbReq.paddr == OFF_CTRL_ZERO)
      |=> apbRsp.prdata[BIT_RESULT] == $past(cmpResult[0]);
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("read result bit differs from recorded result");

  c_flag_set: cover property ($rose(intStatus[0]));
  c_wake: cover property ($rose(wakeup));
  c_irq: cover property ($rose(irq));
  c_read_clear: cover property (readDone && apbReq.paddr == OFF_INT_STATUS && |intStatus);
  c_power_off: cover property ($fell(cmpPowerOn[1]));
endmodule
`default_nettype wire

/* sim/cmp_core_model.sv */
// behavioural model of the two analog comparator cores and the six shared pads
// assumes the bench sets the input voltages as one bit per channel and free pad levels
`timescale 1ns/1ps
`default_nettype none
module cmp_core_model (
  input wire logic [dual_comparator_control_pkg::NUM_CMP-1:0] cmpPowerOn,
  input wire logic [dual_comparator_control_pkg::NUM_CMP-1:0] posAboveNeg,
  input wire logic [dual_comparator_control_pkg::NUM_PINS-1:0] extLevel,
  input wire logic [dual_comparator_control_pkg::NUM_PINS-1:0] padOut,
  input wire logic [dual_comparator_control_pkg::NUM_PINS-1:0] padOe,
  input wire logic [dual_comparator_control_pkg::NUM_PINS-1:0] pullHighOn,
  output logic [dual_comparator_control_pkg::NUM_CMP-1:0] analogResult,
  output logic [dual_comparator_control_pkg::NUM_PINS-1:0] padIn
);
  import dual_comparator_control_pkg::*;
  // an unpowered core gives garbage, so the block must not trust it
  assign analogResult = (cmpPowerOn & posAboveNeg) | (~cmpPowerOn & ~posAboveNeg);
  // driven pad wins, then the pull-high, then whatever the board puts there
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      padIn[p] = padOe[p] ? padOut[p] : (pullHighOn[p] ? 1'b1 : extLevel[p]);
    end
  end
endmodule
`default_nettype wire

/* sim/dual_comparator_control_tb_top.sv */
// self-checking bench for the dual comparator control block
// assumes the core model beside the block and an APB master built here
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_tb_top;
  import dual_comparator_control_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  apb_req_s apbReq = '0;
  apb_rsp_s apbRsp;
  logic [NUM_CMP-1:0] analogResult, cmpPowerOn, cmpHysteresisOn, irqRequest;
  logic [NUM_CMP-1:0] posAboveNeg = 2'h0;
  logic [NUM_PINS-1:0] padIn, padOut, padOe, pullHighOn;
  logic [NUM_PINS-1:0] extLevel = 6'h15;
  logic sleepMode = 1'b0;
  logic wakeup, irq;
  int nFail = 0;
  int samplesChecked = 0;
  int cycles = 0;

  dual_comparator_control dut (.clk_sys(clk_sys), .reset(reset), .apbReq(apbReq),
    .apbRsp(apbRsp), .analogResult(analogResult), .cmpPowerOn(cmpPowerOn),
    .cmpHysteresisOn(cmpHysteresisOn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .pullHighOn(pullHighOn), .sleepMode(sleepMode), .wakeup(wakeup), .irq(irq),
    .irqRequest(irqRequest));
  cmp_core_model core (.cmpPowerOn(cmpPowerOn), .posAboveNeg(posAboveNeg),
    .extLevel(extLevel), .padOut(padOut), .padOe(padOe), .pullHighOn(pullHighOn),
    .analogResult(analogResult), .padIn(padIn));

  always #50 clk_sys = ~clk_sys;

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // generous ceiling; the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nFail = nFail + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one APB transfer; waits for pready as long as it takes, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    chk(n, 32'd2);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, addr, wd, rd, err);
  endtask

  task automatic rdChk(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] msk);
    logic [31:0] rd;
    logic err;
    apb(1'b0, addr, 32'h0, rd, err);
    chk(rd & msk, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // counts wake pulses over a short window after an input change
  task automatic watchWake(output logic [31:0] seen);
    seen = 0;
    repeat (10) begin
      @(posedge clk_sys);
      if (wakeup === 1'b1) seen++;
    end
  endtask

  task automatic tReset;
    rdChk(OFF_CTRL_ZERO, 32'h01, 32'hFFFF_FFFF);
    rdChk(OFF_CTRL_ONE, 32'h01, 32'hFFFF_FFFF);
    chk(cmpHysteresisOn, 32'h3);
    chk(cmpPowerOn, 32'h0);
  endtask

  task automatic tCtrlBits;
    wr(OFF_PULL_ENABLE, 32'h3F);
    wr(OFF_CTRL_ZERO, 32'hFF);
    idle(6);
    rdChk(OFF_CTRL_ZERO, 32'h71, 32'hFFFF_FFFF);
    rdChk(OFF_CTRL_ONE, 32'h01, 32'hFFFF_FFFF);
    chk(cmpPowerOn, 32'h1);
    chk({pullHighOn[4:3], pullHighOn[1:0]}, 32'hC);
    wr(OFF_CTRL_ZERO, 32'h40);
    idle(6);
    rdChk(OFF_CTRL_ZERO, 32'h40, 32'hFFFF_FFFF);
    chk(cmpHysteresisOn, 32'h2);
  endtask

  task automatic tIrq;
    rdChk(OFF_INT_STATUS, 32'h1, 32'h1);
    wr(OFF_INT_MASK, 32'h1);
    @(posedge clk_sys);
    posAboveNeg[0] <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (irq !== 1'b1);
    chk(irqRequest, 32'h1);
    rdChk(OFF_INT_STATUS, 32'h1, 32'h3);
    idle(2);
    chk(irq, 32'h0);
    rdChk(OFF_CTRL_ZERO, 32'h50, 32'hFFFF_FFFF);
    wr(OFF_CTRL_ONE, 32'h40);
    idle(6);
    posAboveNeg[1] <= 1'b1;
    idle(6);
    chk(irq, 32'h0);
    rdChk(OFF_INT_STATUS, 32'h2, 32'h3);
  endtask

  task automatic tWake;
    logic [31:0] seen;
    sleepMode <= 1'b1;
    rdChk(OFF_INT_STATUS, 32'h0, 32'h3);
    posAboveNeg[0] <= 1'b0;
    watchWake(seen);
    chk(seen, 32'h1);
    rdChk(OFF_CTRL_ZERO, 32'h40, 32'hFFFF_FFFF);
    rdChk(OFF_INT_STATUS, 32'h1, 32'h1);
    wr(OFF_INT_STATUS, 32'h1);
    posAboveNeg[0] <= 1'b1;
    watchWake(seen);
    chk(seen, 32'h0);
    sleepMode <= 1'b0;
    rdChk(OFF_INT_STATUS, 32'h1, 32'h1);
  endtask

  task automatic tPorts;
    logic [31:0] rd;
    logic err;
    wr(OFF_OUT_SELECT, 32'h1);
    wr(OFF_PORT_DIR, 32'h3D);
    wr(OFF_PORT_DATA, 32'h02);
    idle(2);
    chk({padOe[2], padOut[2]}, 32'h3);
    chk(padOe[1:0], 32'h0);
    rdChk(OFF_PORT_READ, 32'h2, 32'h3);
    apb(1'b0, 8'h40, 32'h0, rd, err);
    chk({err, rd}, {1'b1, 32'h0});
  endtask

  // software powers both cores down before leaving them unused
  task automatic tPowerDown;
    wr(OFF_CTRL_ZERO, 32'h0);
    wr(OFF_CTRL_ONE, 32'h0);
    idle(2);
    chk(cmpPowerOn, 32'h0);
    chk(pullHighOn, 32'h3F);
    rdChk(OFF_PORT_READ, 32'h3F, 32'h3F);
  endtask

  initial begin
    idle(2);
    reset <= 1'b0;
    tReset();
    tCtrlBits();
    tIrq();
    tWake();
    tPorts();
    tPowerDown();
    end_of_test();
  end
endmodule
`default_nettype wire
